/* bei_top.sv */
`timescale 1ns/10ps
`include "bei_regs.svh"

// How it works
// R1 - An active status bit reaches a pin only while its enable bit is set.
// R2 - The pin for each enabled source comes from map and direction settings.
// R3 - Global reset zeroes every enable; software reads and writes each field.
// R4 - Bits 27, 26, 25 enable processor-bus retry-limit sources.
// R5 - Bits 23, 22, 21 enable processor-bus error sources.
// R6 - Bit 20 enables processor-bus address parity error.
// R7 - Bits 19, 18, 17 enable processor-bus data parity sources.
// R8 - Bits 15, 14, 13 enable second PCI bus error sources.
// R9 - Bit 12 enables second PCI bus address parity error.
// R10 - Bits 11, 10, 9 enable second PCI bus retry-limit sources.
// R11 - Bits 7, 6, 5 first PCI bus errors; bit 4 its address parity.
// R12 - Bits 3, 2, 1 enable first PCI bus retry-limit sources.
// R13 - Bits 31 to 28, 24, 16, 8 and 0 read zero, writes ignored.
// R14 - Single-PCI build: every second PCI bus field reads zero, no effect.
// R15 - Status bits clear on reset, set on event, clear on writing one.
// R16 - Eight interrupt pins chosen by a 3-bit code; 000 is the first PCI line.
module bei_top #(
  parameter bit DUAL_PCI = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire bei_pkg::bei_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  // Error condition pulses, one per status bit
  input wire logic [31:0] err_event,
  // Interrupt pins, open drain, active low
  output logic [7:0] irq_pin_n_out,
  output logic [7:0] irq_pin_oe,
  // Summary interrupt level
  output logic irq_out
);

  // Sources on the processor bus
  localparam logic [31:0] PB_BITS =
    (32'h0000_0001 << `BEI_PB_RETRY_PCI_A) | // R4
    (32'h0000_0001 << `BEI_PB_RETRY_PCI_B) | // R4
    (32'h0000_0001 << `BEI_PB_RETRY_DMA) | // R4
    (32'h0000_0001 << `BEI_PB_ERR_PCI_A) | // R5
    (32'h0000_0001 << `BEI_PB_ERR_PCI_B) | // R5
    (32'h0000_0001 << `BEI_PB_ERR_DMA) | // R5
    (32'h0000_0001 << `BEI_PB_ADDR_PAR) | // R6
    (32'h0000_0001 << `BEI_PB_DPAR_PCI_A) | // R7
    (32'h0000_0001 << `BEI_PB_DPAR_PCI_B) | // R7
    (32'h0000_0001 << `BEI_PB_DPAR_DMA); // R7

  // Second PCI bus block, bits 15 to 9
  localparam logic [31:0] PCIB_BLOCK =
    ((32'h0000_0001 << (`BEI_PCIB_HI + 1)) - 32'h0000_0001) &
    ~((32'h0000_0001 << `BEI_PCIB_LO) - 32'h0000_0001); // R8 R9 R10

  // Sources on the first PCI bus
  localparam logic [31:0] PA_BITS =
    (32'h0000_0001 << `BEI_PA_ERR_PCI_B) | // R11
    (32'h0000_0001 << `BEI_PA_ERR_PB) | // R11
    (32'h0000_0001 << `BEI_PA_ERR_DMA) | // R11
    (32'h0000_0001 << `BEI_PA_ADDR_PAR) | // R11
    (32'h0000_0001 << `BEI_PA_RETRY_PCI_B) | // R12
    (32'h0000_0001 << `BEI_PA_RETRY_PB) | // R12
    (32'h0000_0001 << `BEI_PA_RETRY_DMA); // R12

  // Every field that names the second PCI bus
  localparam logic [31:0] PCIB_FIELDS = PCIB_BLOCK |
    (32'h0000_0001 << `BEI_PB_RETRY_PCI_B) |
    (32'h0000_0001 << `BEI_PB_ERR_PCI_B) |
    (32'h0000_0001 << `BEI_PB_DPAR_PCI_B) |
    (32'h0000_0001 << `BEI_PA_ERR_PCI_B) |
    (32'h0000_0001 << `BEI_PA_RETRY_PCI_B);

  // Implemented bits; everything else is reserved
  localparam logic [31:0] ALL_BITS = PB_BITS | PCIB_BLOCK | PA_BITS; // R13
  localparam logic [31:0] VALID =
    DUAL_PCI ? ALL_BITS : (ALL_BITS & ~PCIB_FIELDS); // R14

  logic [31:0] enable;
  logic [31:0] status;
  logic [7:0] direction;
  bei_pkg::bei_map_code_t map_code [32];
  logic [31:0] next_rdata;
  logic [7:0] next_pin;
  logic [31:0] active;

  // Address hits
  logic hit_en;
  logic hit_st;
  logic hit_dir;
  logic hit_map;
  logic [1:0] map_sel;
  logic [11:0] map_rel;

  always_comb begin
    map_rel = bus_req.addr - `BEI_MAP0_OFF;
    map_sel = map_rel[3:2];
    hit_en = 1'b0;
    hit_st = 1'b0;
    hit_dir = 1'b0;
    hit_map = 1'b0;
    if (bus_req.addr == `BEI_ENABLE_OFF) begin
      hit_en = 1'b1;
    end else if (bus_req.addr == `BEI_STATUS_OFF) begin
      hit_st = 1'b1;
    end else if (bus_req.addr == `BEI_DIR_OFF) begin
      hit_dir = 1'b1;
    end else if (bus_req.addr >= `BEI_MAP0_OFF &&
                 bus_req.addr < `BEI_MAP0_OFF + `BEI_MAP_STRIDE * `BEI_MAP_REGS &&
                 bus_req.addr[1:0] == 2'b00) begin
      hit_map = 1'b1;
    end
  end

  // Enable register, reserved bits never stored
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      enable <= `BEI_ENABLE_RST; // R3
    end else if (bus_req.wr && hit_en) begin
      enable <= bus_req.wdata & VALID; // R3 R13 R14
    end
  end

  // Sticky status, the event wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      status <= `BEI_STATUS_RST; // R15
    end else begin
      status <= ((bus_req.wr && hit_st) ? (status & ~bus_req.wdata) : status) |
                (err_event & VALID); // R15
    end
  end

  // Direction register, one bit per pin, 1 means drive it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      direction <= `BEI_DIR_RST;
    end else if (bus_req.wr && hit_dir) begin
      direction <= bus_req.wdata[7:0];
    end
  end

  // Map registers, eight 4-bit fields each
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int s = 0; s < 32; s++) begin
        map_code[s] <= `BEI_MAP_RST;
      end
    end else if (bus_req.wr && hit_map) begin
      for (int f = 0; f < 8; f++) begin
        map_code[{map_sel, f[2:0]}] <= bus_req.wdata[f*`BEI_MAP_FIELD_W +: `BEI_MAP_CODE_W]; // R16
      end
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (hit_en) begin
      next_rdata = enable; // R3
    end else if (hit_st) begin
      next_rdata = status;
    end else if (hit_dir) begin
      next_rdata = {24'h00_0000, direction};
    end else if (hit_map) begin
      for (int f = 0; f < 8; f++) begin
        next_rdata[f*`BEI_MAP_FIELD_W +: `BEI_MAP_CODE_W] = map_code[{map_sel, f[2:0]}];
      end
    end
  end

  // Read data stands for one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      bus_rdata <= 32'h0000_0000;
    end else if (bus_req.rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= 32'h0000_0000;
    end
  end

  // Gated sources routed to their selected pin
  always_comb begin
    active = status & enable; // R1
    next_pin = 8'h00;
    for (int s = 0; s < 32; s++) begin
      if (active[s]) begin
        next_pin[map_code[s]] = 1'b1; // R2 R16
      end
    end
    next_pin = next_pin & direction; // R2
  end

  // Pin drivers and summary level
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_pin_oe <= 8'h00;
      irq_pin_n_out <= 8'h00;
      irq_out <= 1'b0;
    end else begin
      irq_pin_oe <= next_pin; // R1
      irq_pin_n_out <= 8'h00;
      irq_out <= |active; // R1
    end
  end

  // Checks
  reset_clears_a: assert property (@(posedge ref_clk) // R3
    sys_rst |=> (enable == 32'h0000_0000 && status == 32'h0000_0000))
    else $error("enable or status not cleared by reset");

  enable_write_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    (bus_req.wr && bus_req.addr == `BEI_ENABLE_OFF) |=>
      enable == ($past(bus_req.wdata) & VALID))
    else $error("enable write not stored");

  enable_readback_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    (bus_req.rd && bus_req.addr == `BEI_ENABLE_OFF) |=> bus_rdata == $past(enable))
    else $error("enable read back wrong");

  reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    (enable & 32'hF101_0101) == 32'h0000_0000)
    else $error("reserved enable bit set");

  single_pci_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
    !DUAL_PCI |-> (enable & PCIB_FIELDS) == 32'h0000_0000)
    else $error("second bus field set in single build");

  gate_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
    (status & enable) == 32'h0000_0000 |=> !irq_out && irq_pin_oe == 8'h00)
    else $error("interrupt without enabled source");

  event_set_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
    (err_event & VALID) != 32'h0000_0000 |=>
      (status & $past(err_event) & VALID) == ($past(err_event) & VALID))
    else $error("event did not set status");

  status_clear_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
    (bus_req.wr && bus_req.addr == `BEI_STATUS_OFF && err_event == 32'h0000_0000) |=>
      status == ($past(status) & ~$past(bus_req.wdata)))
    else $error("write one to clear failed");

  pin_dir_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    ##1 (irq_pin_oe & ~$past(direction)) == 8'h00)
    else $error("pin driven against direction");

  pin_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R16
    (enable[`BEI_PA_ADDR_PAR] && status[`BEI_PA_ADDR_PAR] && direction[0] &&
     map_code[`BEI_PA_ADDR_PAR] == 3'h0) |=> irq_pin_oe[0])
    else $error("code 000 did not reach pin 0");

  // Bus, status and pin checks
  reset_outputs_a: assert property (@(posedge ref_clk) // R3
    sys_rst |=> (bus_rdata == 32'h0000_0000 && !irq_out && irq_pin_oe == 8'h00))
    else $error("outputs not cleared by reset");

  enable_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    !(bus_req.wr && bus_req.addr == `BEI_ENABLE_OFF) |=> enable == $past(enable))
    else $error("enable changed without a write");

  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    !bus_req.rd |=> bus_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R3
    (bus_req.rd && !hit_en && !hit_st && !hit_dir && !hit_map) |=>
      bus_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  reserved_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    (bus_req.rd && bus_req.addr == `BEI_ENABLE_OFF) |=>
      (bus_rdata & 32'hF101_0101) == 32'h0000_0000)
    else $error("reserved bit read as one");

  status_reserved_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R13
    (status & 32'hF101_0101) == 32'h0000_0000)
    else $error("reserved status bit set");

  single_status_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R14
    !DUAL_PCI |-> (status & PCIB_FIELDS) == 32'h0000_0000)
    else $error("second bus status set in single build");

  status_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R15
    (!(bus_req.wr && bus_req.addr == `BEI_STATUS_OFF) && err_event == 32'h0000_0000) |=>
      status == $past(status))
    else $error("status changed without cause");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
    (status & enable) != 32'h0000_0000 |=> irq_out)
    else $error("enabled source did not raise interrupt");

  pin_needs_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R1
    irq_pin_oe != 8'h00 |-> irq_out)
    else $error("pin driven with no active source");

  dir_block_a: assert property (@(posedge ref_clk) disable iff (sys_rst) // R2
    direction == 8'h00 |=> irq_pin_oe == 8'h00)
    else $error("pin driven with every direction off");

endmodule

/* bei_regs.svh */
`ifndef BEI_REGS_SVH
`define BEI_REGS_SVH

// Register byte offsets
`define BEI_ENABLE_OFF 12'h41C
`define BEI_STATUS_OFF 12'h414
`define BEI_MAP0_OFF 12'h440
`define BEI_DIR_OFF 12'h450
`define BEI_MAP_STRIDE 12'h004
`define BEI_MAP_REGS 4

// Reset values
`define BEI_ENABLE_RST 32'h0000_0000
`define BEI_STATUS_RST 32'h0000_0000
`define BEI_DIR_RST 8'h00
`define BEI_MAP_RST 3'h0

// Map field layout: 8 fields of 4 bits, code in the low 3
`define BEI_MAP_FIELD_W 4
`define BEI_MAP_CODE_W 3
`define BEI_PIN_COUNT 8

// Processor-bus enable positions
`define BEI_PB_RETRY_PCI_A 27
`define BEI_PB_RETRY_PCI_B 26
`define BEI_PB_RETRY_DMA 25
`define BEI_PB_ERR_PCI_A 23
`define BEI_PB_ERR_PCI_B 22
`define BEI_PB_ERR_DMA 21
`define BEI_PB_ADDR_PAR 20
`define BEI_PB_DPAR_PCI_A 19
`define BEI_PB_DPAR_PCI_B 18
`define BEI_PB_DPAR_DMA 17

// Second PCI bus enable positions (bits 15 to 9)
`define BEI_PCIB_LO 9
`define BEI_PCIB_HI 15

// First PCI bus enable positions
`define BEI_PA_ERR_PCI_B 7
`define BEI_PA_ERR_PB 6
`define BEI_PA_ERR_DMA 5
`define BEI_PA_ADDR_PAR 4
`define BEI_PA_RETRY_PCI_B 3
`define BEI_PA_RETRY_PB 2
`define BEI_PA_RETRY_DMA 1

`endif

/* bei_pkg.sv */
package bei_pkg;

  // One register access from software
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bei_bus_req_t;

  // Three-bit pin selector per source
  typedef logic [2:0] bei_map_code_t;

endpackage

/* tb.sv */
`timescale 1ns/10ps
`include "bei_regs.svh"

module tb;
  logic ref_clk;
  logic sys_rst;
  bei_pkg::bei_bus_req_t bus_req;
  logic [31:0] bus_rdata;
  logic [31:0] single_rdata;
  logic single_irq;
  logic [31:0] err_event;
  logic [7:0] irq_pin_n_out;
  logic [7:0] irq_pin_oe;
  logic irq_out;
  logic [31:0] v;
  logic [31:0] vs;
  int fail_count;
  int check_count;
  localparam logic [31:0] VALID = 32'h0EFE_FEFE;
  localparam logic [31:0] VALID_S = 32'h0ABA_0076;

  // Full two-bus build under test
  bei_top dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .err_event(err_event), .irq_pin_n_out(irq_pin_n_out), .irq_pin_oe(irq_pin_oe),
    .irq_out(irq_out)
  );

  // Single-bus build sharing the same stimulus
  bei_top #(.DUAL_PCI(1'b0)) dut_single (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(single_rdata),
    .err_event(err_event), .irq_pin_n_out(), .irq_pin_oe(), .irq_out(single_irq)
  );

  // Clock at 8 ns
  always #4 ref_clk = ~ref_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1;
    v = bus_rdata;
    vs = single_rdata;
  endtask

  // Let the next edge land before looking
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask

  // One-cycle condition pulse, then wait for the interrupt lag
  task automatic pulse(input int i);
    @(posedge ref_clk);
    err_event <= 32'h0000_0001 << i;
    @(posedge ref_clk);
    err_event <= 32'h0000_0000;
    settle();
  endtask

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    test_done();
  end

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    bus_req = '0;
    err_event = 32'h0000_0000;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    // Reset state
    rd(`BEI_ENABLE_OFF);
    chk(v, 32'h0000_0000);
    rd(`BEI_STATUS_OFF);
    chk(v, 32'h0000_0000);
    chk({24'h0, irq_pin_oe}, 32'h0000_0000);
    $display("test reset done");
    // Every enable field on its own, both builds
    for (int i = 0; i < 32; i++) begin
      wr(`BEI_ENABLE_OFF, 32'h0000_0001 << i);
      rd(`BEI_ENABLE_OFF);
      chk(v, (32'h0000_0001 << i) & VALID);
      chk(vs, (32'h0000_0001 << i) & VALID_S);
    end
    wr(`BEI_ENABLE_OFF, 32'hFFFF_FFFF);
    rd(`BEI_ENABLE_OFF);
    chk(v, VALID);
    chk(vs, VALID_S);
    wr(12'h7F0, 32'hFFFF_FFFF);
    rd(12'h7F0);
    chk(v, 32'h0000_0000);
    $display("test enable fields done");
    // Disabled source sets status but raises nothing
    wr(`BEI_DIR_OFF, 32'h0000_0001);
    wr(`BEI_ENABLE_OFF, 32'h0000_0000);
    pulse(4);
    chk({31'h0, irq_out}, 32'h0000_0000);
    rd(`BEI_STATUS_OFF);
    chk(v, 32'h0000_0010);
    wr(`BEI_ENABLE_OFF, 32'h0000_0010);
    settle();
    chk({31'h0, irq_out}, 32'h0000_0001);
    chk({24'h0, irq_pin_oe}, 32'h0000_0001);
    chk({24'h0, irq_pin_n_out}, 32'h0000_0000);
    // Remap source 4 to pin code 3
    wr(`BEI_MAP0_OFF, 32'h0003_0000);
    wr(`BEI_DIR_OFF, 32'h0000_0009);
    settle();
    chk({24'h0, irq_pin_oe}, 32'h0000_0008);
    wr(`BEI_STATUS_OFF, 32'h0000_0010);
    settle();
    chk({31'h0, irq_out}, 32'h0000_0000);
    rd(`BEI_STATUS_OFF);
    chk(v, 32'h0000_0000);
    pulse(0);
    rd(`BEI_STATUS_OFF);
    chk(v, 32'h0000_0000);
    wr(`BEI_MAP0_OFF, 32'h0000_0000);
    wr(`BEI_DIR_OFF, 32'h0000_0001);
    $display("test masking done");
    // Each valid source alone raises and drops the interrupt
    for (int i = 0; i < 32; i++) begin
      if (VALID[i]) begin
        wr(`BEI_ENABLE_OFF, 32'h0000_0001 << i);
        pulse(i);
        chk({31'h0, irq_out}, 32'h0000_0001);
        chk({24'h0, irq_pin_oe}, 32'h0000_0001);
        chk({31'h0, single_irq}, {31'h0, VALID_S[i]});
        wr(`BEI_STATUS_OFF, 32'h0000_0001 << i);
        settle();
        chk({31'h0, irq_out}, 32'h0000_0000);
        chk({31'h0, single_irq}, 32'h0000_0000);
      end
    end
    $display("test per source done");
    // Reset in mid-run with a source pending
    wr(`BEI_ENABLE_OFF, 32'hFFFF_FFFF);
    pulse(4);
    chk({31'h0, irq_out}, 32'h0000_0001);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk({31'h0, irq_out}, 32'h0000_0000);
    chk({24'h0, irq_pin_oe}, 32'h0000_0000);
    rd(`BEI_ENABLE_OFF);
    chk(v, 32'h0000_0000);
    chk(vs, 32'h0000_0000);
    rd(`BEI_STATUS_OFF);
    chk(v, 32'h0000_0000);
    rd(`BEI_DIR_OFF);
    chk(v, 32'h0000_0000);
    $display("test mid-run reset done");
    test_done();
  end
endmodule
